/* File: cfg_fifo.sv */
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module cfg_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("cfg_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic             do_push;
    logic             do_pop;

    // honest full and empty from the occupancy count
    assign in_ready  = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign do_push   = in_valid && in_ready;
    assign do_pop    = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    // storage write
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(do_push) - (PW+1)'(do_pop);
        end
    end

    // pointers must meet whenever the fifo is empty or full
    chk_ptr_agree: assert property (@(posedge clk) disable iff (rst)
        (count == '0 || count == (PW+1)'(DEPTH)) |-> wr_ptr == rd_ptr) else $error("fifo pointers out of step");
endmodule

/* File: cfg_loader.sv */
// configuration loader: boot source choice, flash read, onetime store copy, target load
// assumes pins arrive asynchronous to core_clk and the pad logic resolves each enable
`timescale 1ns/1ns
module cfg_loader #(
    parameter int CFG_WORDS  = 16,
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       config_reset_n,
    input  wire logic       target_strap,
    input  wire logic       serial_in_pin,
    output logic            serial_out_pin,
    output logic            serial_out_oe_n,
    input  wire logic       serial_clock_in,
    output logic            serial_clock_out,
    output logic            serial_clock_oe_n,
    input  wire logic       spi_select_in,
    output logic            spi_select_out,
    output logic            spi_select_oe_n,
    input  wire logic       load_hold,
    input  wire logic [$clog2(CFG_WORDS)-1:0] cfg_rd_addr,
    output logic      [7:0] cfg_rd_data,
    output logic            config_done,
    output logic            target_overrun,
    output logic            store_locked
);
    localparam int AW         = $clog2(CFG_WORDS);
    localparam int WC         = AW + 1;
    localparam int TOTAL_BITS = cfgload_pkg::HDR_BITS + CFG_WORDS * 8;
    localparam int CW         = $clog2(TOTAL_BITS + 1);
    localparam logic [CW-1:0] HDR_N   = CW'(cfgload_pkg::HDR_BITS);
    localparam logic [CW-1:0] LAST_N  = CW'(TOTAL_BITS - 1);
    localparam logic [WC-1:0] WORDS_N = WC'(CFG_WORDS);
    localparam logic [7:0]    HALF_N  = 8'(cfgload_pkg::SCK_HALF_CYC - 1);

    if (CFG_WORDS < 2 || (1 << AW) != CFG_WORDS) begin : g_bad_words
        $error("cfg_loader image size must be a power of two of at least 2");
    end

    function automatic logic is_rise(input logic cur, input logic prev);
        return cur && !prev;
    endfunction

    cfgload_pkg::load_state_t state;
    logic [cfgload_pkg::SY_N-1:0] meta;
    logic [cfgload_pkg::SY_N-1:0] sy;
    logic                         sck_d;
    logic                         ss_d;
    logic                         creset_n;
    logic [7:0]                   config_ram [CFG_WORDS];
    logic [7:0]                   onetime_config_store [CFG_WORDS];
    logic [7:0]                   div;
    logic                         sck_q;
    logic [CW-1:0]                bit_cnt;
    logic [cfgload_pkg::HDR_BITS-1:0] hdr;
    logic [7:0]                   rx_byte;
    logic                         tick;
    logic                         ctrl_rise;
    logic                         ctrl_fall;
    logic [WC-1:0]                rd_idx;
    logic [2:0]                   tbit;
    logic                         op_seen;
    logic [7:0]                   op;
    logic                         tgt_so;
    logic                         store_dirty;
    logic                         tgt_rise;
    logic [7:0]                   tgt_byte;
    logic [6:0]                   tshift;
    logic                         src_push;
    logic [8:0]                   src_data;
    logic                         push_valid;
    logic [8:0]                   push_data;
    logic                         push_ready;
    logic                         sink_valid;
    logic [8:0]                   sink_data;
    logic                         sink_ready;
    logic [WC-1:0]                wr_count;
    logic [AW-1:0]                st_idx;

    assign creset_n = sy[cfgload_pkg::SY_CRST];

    // two-flop synchronisers for every pin input
    always_ff @(posedge core_clk) begin
        meta <= {target_strap, config_reset_n, spi_select_in, serial_clock_in, serial_in_pin};
        sy   <= meta;
    end

    // delayed copies for edge finding
    always_ff @(posedge core_clk) begin
        sck_d <= sy[cfgload_pkg::SY_SCK];
        ss_d  <= sy[cfgload_pkg::SY_SS];
    end

    // boot sequencing
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= cfgload_pkg::ST_HOLD;
        end else if (!creset_n) begin
            state <= cfgload_pkg::ST_HOLD;
        end else begin
            case (state)
                cfgload_pkg::ST_HOLD: state <= cfgload_pkg::ST_SAMPLE;
                cfgload_pkg::ST_SAMPLE: begin
                    if (sy[cfgload_pkg::SY_SS] == cfgload_pkg::SEL_ONETIME) begin
                        state <= cfgload_pkg::ST_STORE;
                    end else if (sy[cfgload_pkg::SY_STRAP]) begin
                        state <= cfgload_pkg::ST_TARGET;
                    end else begin
                        state <= cfgload_pkg::ST_CTRL;
                    end
                end
                cfgload_pkg::ST_CTRL: begin
                    if (ctrl_fall && bit_cnt == LAST_N) begin
                        state <= cfgload_pkg::ST_CTRL_END;
                    end
                end
                cfgload_pkg::ST_CTRL_END, cfgload_pkg::ST_STORE, cfgload_pkg::ST_TARGET: begin
                    if (wr_count == WORDS_N) begin
                        state <= cfgload_pkg::ST_DONE;
                    end
                end
                cfgload_pkg::ST_DONE: state <= cfgload_pkg::ST_DONE;
                default: state <= cfgload_pkg::ST_HOLD;
            endcase
        end
    end

    // controller clock divider, stalled while the buffer refuses a byte
    assign tick      = (state == cfgload_pkg::ST_CTRL) && (div == HALF_N) && !(push_valid && !push_ready);
    assign ctrl_rise = tick && !sck_q;
    assign ctrl_fall = tick && sck_q;

    // controller shift engine: header out msb first, data in on rising edges
    always_ff @(posedge core_clk) begin
        if (sys_rst || state != cfgload_pkg::ST_CTRL) begin
            div     <= '0;
            sck_q   <= 1'b0;
            bit_cnt <= '0;
            hdr     <= {cfgload_pkg::FAST_READ_CMD, cfgload_pkg::FLASH_START_ADDR, cfgload_pkg::DUMMY_BYTE};
            rx_byte <= '0;
        end else if (tick) begin
            div   <= '0;
            sck_q <= ~sck_q;
            if (ctrl_rise && bit_cnt >= HDR_N) begin
                rx_byte <= {rx_byte[6:0], sy[cfgload_pkg::SY_SI]};
            end
            if (ctrl_fall) begin
                hdr     <= {hdr[cfgload_pkg::HDR_BITS-2:0], 1'b0};
                bit_cnt <= bit_cnt + 1'b1;
            end
        end else if (div != HALF_N) begin
            div <= div + 1'b1;
        end
    end

    // target receive: first byte of a frame is the destination
    assign tgt_rise = (state == cfgload_pkg::ST_TARGET) && !sy[cfgload_pkg::SY_SS] &&
                      is_rise(sy[cfgload_pkg::SY_SCK], sck_d);
    assign tgt_byte = {tshift, sy[cfgload_pkg::SY_SI]};

    always_ff @(posedge core_clk) begin
        if (sys_rst || state != cfgload_pkg::ST_TARGET || sy[cfgload_pkg::SY_SS]) begin
            tbit    <= '0;
            tshift  <= '0;
            op_seen <= 1'b0;
            op      <= '0;
            tgt_so  <= 1'b0;
        end else if (tgt_rise) begin
            tshift <= {tshift[5:0], sy[cfgload_pkg::SY_SI]};
            tbit   <= tbit + 1'b1;
            tgt_so <= sy[cfgload_pkg::SY_SI]; // echo of the last bit
            if (tbit == 3'h7 && !op_seen) begin
                op_seen <= 1'b1;
                op      <= tgt_byte;
            end
        end
    end

    // byte sources into the buffer; bit 8 marks a store write
    always_comb begin
        src_push = 1'b0;
        src_data = '0;
        if (ctrl_rise && bit_cnt >= HDR_N && bit_cnt[2:0] == 3'h7) begin
            src_push = 1'b1;
            src_data = {1'b0, rx_byte[6:0], sy[cfgload_pkg::SY_SI]};
        end else if (state == cfgload_pkg::ST_STORE && rd_idx != WORDS_N && !push_valid) begin
            src_push = 1'b1;
            src_data = {1'b0, onetime_config_store[rd_idx[AW-1:0]]};
        end else if (tgt_rise && tbit == 3'h7 && op_seen) begin
            src_push = (op == cfgload_pkg::TGT_OP_LOAD_RAM) || (op == cfgload_pkg::TGT_OP_PROG_STORE);
            src_data = {op == cfgload_pkg::TGT_OP_PROG_STORE, tgt_byte};
        end
    end

    // staging register, overrun only possible from the free-running host
    always_ff @(posedge core_clk) begin
        if (sys_rst || !creset_n) begin
            push_valid     <= 1'b0;
            push_data      <= '0;
            target_overrun <= 1'b0;
            rd_idx         <= '0;
        end else begin
            if (src_push) begin
                push_valid <= 1'b1;
                push_data  <= src_data;
            end else if (push_ready) begin
                push_valid <= 1'b0;
            end
            if (src_push && push_valid && !push_ready) begin
                target_overrun <= 1'b1;
            end
            if (src_push && state == cfgload_pkg::ST_STORE) begin
                rd_idx <= rd_idx + 1'b1;
            end
        end
    end

    cfg_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH)
    ) cfg_fifo_i (
        .clk       (core_clk),
        .rst       (sys_rst || !creset_n),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (sink_valid),
        .out_ready (sink_ready),
        .out_data  (sink_data)
    );

    assign sink_ready = !load_hold;

    // drain into the configuration RAM or the onetime store
    always_ff @(posedge core_clk) begin
        if (sink_valid && sink_ready) begin
            if (!sink_data[8] && wr_count != WORDS_N) begin
                config_ram[wr_count[AW-1:0]] <= sink_data[7:0];
            end
            if (sink_data[8] && !store_locked) begin
                onetime_config_store[st_idx] <= sink_data[7:0];
            end
        end
        cfg_rd_data <= config_ram[cfg_rd_addr];
    end

    // write counters, done flag and store lock
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_count     <= '0;
            st_idx       <= '0;
            config_done  <= 1'b0;
            store_dirty  <= 1'b0;
            store_locked <= 1'b0;
        end else begin
            if (!creset_n || state == cfgload_pkg::ST_HOLD) begin
                wr_count <= '0;
                st_idx   <= '0;
            end else if (sink_valid && sink_ready) begin
                if (!sink_data[8] && wr_count != WORDS_N) begin
                    wr_count <= wr_count + 1'b1;
                end
                if (sink_data[8] && !store_locked) begin
                    st_idx      <= st_idx + 1'b1;
                    store_dirty <= 1'b1;
                end
            end
            if (is_rise(sy[cfgload_pkg::SY_SS], ss_d) && store_dirty) begin
                store_locked <= 1'b1;
            end
            config_done <= creset_n && state == cfgload_pkg::ST_DONE;
        end
    end

    // pin drive: enables low while driving, all released once done
    assign serial_clock_out  = sck_q;
    assign serial_clock_oe_n = !(state == cfgload_pkg::ST_CTRL || state == cfgload_pkg::ST_CTRL_END);
    assign spi_select_out    = (state != cfgload_pkg::ST_CTRL);
    assign spi_select_oe_n   = serial_clock_oe_n;
    assign serial_out_pin    = (state == cfgload_pkg::ST_TARGET) ? tgt_so : hdr[cfgload_pkg::HDR_BITS-1];
    assign serial_out_oe_n   = !(state == cfgload_pkg::ST_CTRL || state == cfgload_pkg::ST_TARGET);

    chk_hold_off: assert property (@(posedge core_clk) disable iff (sys_rst)
        !creset_n |=> state == cfgload_pkg::ST_HOLD) else $error("load runs while config reset low");
    chk_done_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        !creset_n |=> !config_done) else $error("done stays high through config reset");
    chk_resample: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(creset_n) |=> state == cfgload_pkg::ST_SAMPLE) else $error("no sampling after config reset");
    chk_store_path: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == cfgload_pkg::ST_SAMPLE && creset_n && sy[cfgload_pkg::SY_SS]) |=> state == cfgload_pkg::ST_STORE)
        else $error("select high did not pick the onetime store");
    chk_ext_path: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == cfgload_pkg::ST_SAMPLE && creset_n && !sy[cfgload_pkg::SY_SS]) |=>
        (state == cfgload_pkg::ST_CTRL || state == cfgload_pkg::ST_TARGET)) else $error("select low not external");
    chk_cmd_bits: assert property (@(posedge core_clk) disable iff (sys_rst)
        (ctrl_rise && bit_cnt < CW'(cfgload_pkg::CMD_BITS)) |->
        serial_out_pin == cfgload_pkg::FAST_READ_CMD[3'(3'h7 - bit_cnt[2:0])]) else $error("wrong read command bit");
    chk_release: assert property (@(posedge core_clk) disable iff (sys_rst)
        config_done |-> (serial_out_oe_n && serial_clock_oe_n && spi_select_oe_n)) else $error("pins not released");
    chk_clock_dir: assert property (@(posedge core_clk) disable iff (sys_rst)
        state == cfgload_pkg::ST_TARGET |-> serial_clock_oe_n && spi_select_oe_n) else $error("drives host clock");
    chk_select_end: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(state == cfgload_pkg::ST_CTRL_END) |-> spi_select_out && !spi_select_oe_n && !config_done)
        else $error("select not raised before done");
    chk_done_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == cfgload_pkg::ST_DONE && creset_n) |=> config_done) else $error("done not raised");
endmodule

/* File: cfgload_pkg.sv */
// constants, pin index map and state type for the configuration loader
// assumes a 100 MHz core clock; used by the loader only, its data buffer does not import it
package cfgload_pkg;
    // core clock and generated flash clock timing
    localparam int CORE_PERIOD_NS = 10;
    localparam int SCK_HALF_NS    = 40;
    localparam int SCK_HALF_CYC   = (SCK_HALF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

    // flash read header
    localparam logic [7:0]  FAST_READ_CMD    = 8'h0b;
    localparam int          CMD_BITS         = 8;
    localparam int          ADDR_BITS        = 24;
    localparam int          DUMMY_BITS       = 8;
    localparam int          HDR_BITS         = CMD_BITS + ADDR_BITS + DUMMY_BITS;
    localparam logic [23:0] FLASH_START_ADDR = 24'h000000;
    localparam logic [7:0]  DUMMY_BYTE       = 8'h00;

    // boot source levels of the sampled chip select
    localparam logic SEL_EXTERNAL = 1'b0;
    localparam logic SEL_ONETIME  = 1'b1;

    // first byte of a target frame selects its destination
    localparam logic [7:0] TGT_OP_LOAD_RAM   = 8'h01;
    localparam logic [7:0] TGT_OP_PROG_STORE = 8'h02;

    // synchroniser lanes
    localparam int SY_SI    = 0;
    localparam int SY_SCK   = 1;
    localparam int SY_SS    = 2;
    localparam int SY_CRST  = 3;
    localparam int SY_STRAP = 4;
    localparam int SY_N     = 5;

    typedef enum {ST_HOLD, ST_SAMPLE, ST_CTRL, ST_CTRL_END, ST_STORE, ST_TARGET, ST_DONE} load_state_t;
endpackage

/* File: spi_config_boot_loader_bench.sv */
// self-checking bench for the loader with a flash model and a bench-driven host
// assumes the loader defaults: 16 words, fifo depth 4, 100 MHz core clock
`timescale 1ns/1ns
module spi_config_boot_loader_bench;
    localparam int W = 16;
    logic core_clk = 0, sys_rst = 1, config_reset_n = 1, target_strap = 0, load_hold = 0;
    logic host_sel = 0, host_sck = 0, host_mosi = 0, rd_req = 0, rd_d1 = 0;
    logic [3:0] cfg_rd_addr = '0;
    logic [W*8-1:0] image_a, image_b, image_c;
    logic [7:0] exp_q[$];
    logic [39:0] header;
    int n_errors = 0, tests_run = 0, seed = 15227;
    wire logic serial_out_pin, serial_out_oe_n, serial_clock_out, serial_clock_oe_n;
    wire logic spi_select_out, spi_select_oe_n, config_done, target_overrun, store_locked, flash_miso;
    wire logic [7:0] cfg_rd_data;
    // pad resolution: the loader's enables win over the host
    wire logic sel_wire = spi_select_oe_n ? host_sel : spi_select_out;
    wire logic sck_wire = serial_clock_oe_n ? host_sck : serial_clock_out;
    wire logic si_wire  = target_strap ? host_mosi : flash_miso;
    // released select floats to its pull-up, so the flash sees a fresh frame on every controller boot
    wire logic flash_cs_n = spi_select_oe_n ? 1'b1 : spi_select_out;

    always #5 core_clk = ~core_clk;

    cfg_loader cfg_loader_i (.core_clk(core_clk), .sys_rst(sys_rst), .config_reset_n(config_reset_n),
        .target_strap(target_strap), .serial_in_pin(si_wire), .serial_out_pin(serial_out_pin),
        .serial_out_oe_n(serial_out_oe_n), .serial_clock_in(sck_wire), .serial_clock_out(serial_clock_out),
        .serial_clock_oe_n(serial_clock_oe_n), .spi_select_in(sel_wire), .spi_select_out(spi_select_out),
        .spi_select_oe_n(spi_select_oe_n), .load_hold(load_hold), .cfg_rd_addr(cfg_rd_addr),
        .cfg_rd_data(cfg_rd_data), .config_done(config_done), .target_overrun(target_overrun),
        .store_locked(store_locked));

    spi_flash_model #(.WORDS(W)) spi_flash_model_i (.sck(sck_wire), .cs_n(flash_cs_n), .mosi(serial_out_pin),
        .image(image_a), .miso(flash_miso), .header(header));

    task automatic end_of_test();
        if (n_errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic check_val(string what, logic [39:0] exp, logic [39:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask

    // read port monitor: data lands one cycle after the address
    always @(posedge core_clk) begin
        rd_d1 <= rd_req;
        if (rd_d1) check_val("cfg_rd_data", {32'h0, exp_q.pop_front()}, {32'h0, cfg_rd_data});
    end

    // walk the whole configuration ram, noting each expected word
    task automatic read_ram(logic [W*8-1:0] img);
        for (int n = 0; n < W; n++) begin
            @(posedge core_clk);
            cfg_rd_addr <= n[3:0];
            rd_req <= 1'b1;
            exp_q.push_back(img[(W-1-n)*8 +: 8]);
        end
        @(posedge core_clk);
        rd_req <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    // wait for done with the buffer drain stalled at random
    task automatic wait_done();
        int i;
        for (i = 0; i < 20000 && config_done !== 1'b1; i++) begin
            @(posedge core_clk);
            load_hold <= 1'($random(seed));
        end
        @(posedge core_clk);
        load_hold <= 1'b0;
        check_val("config_done", 1, config_done);
        check_val("released_oe_n", 3'b111, {serial_out_oe_n, serial_clock_oe_n, spi_select_oe_n});
    endtask

    // config reset pulse; select level presented for the boot sample
    task automatic reboot(logic sel);
        @(posedge core_clk);
        config_reset_n <= 1'b0;
        host_sel <= sel;
        repeat (40) @(posedge core_clk);
        check_val("done_in_reset", 0, config_done);
        check_val("oe_n_in_reset", 3'b111, {serial_out_oe_n, serial_clock_oe_n, spi_select_oe_n});
        config_reset_n <= 1'b1;
    endtask

    // one host byte, msb first, 160 ns host clock
    task automatic host_byte(logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            host_mosi <= b[i];
            repeat (8) @(posedge core_clk);
            host_sck <= 1'b1;
            repeat (8) @(posedge core_clk);
            host_sck <= 1'b0;
        end
    endtask

    // host frame: select held low for the whole frame
    task automatic host_frame(logic [7:0] op, logic [W*8-1:0] img);
        @(posedge core_clk);
        host_sel <= 1'b0;
        repeat (8) @(posedge core_clk);
        host_byte(op);
        for (int n = 0; n < W; n++) host_byte(img[(W-1-n)*8 +: 8]);
        repeat (8) @(posedge core_clk);
        host_sel <= 1'b1;
        repeat (8) @(posedge core_clk);
    endtask

    initial begin
        repeat (60000) @(posedge core_clk);
        n_errors++;
        end_of_test();
    end

    initial begin
        for (int k = 0; k < 4; k++) begin
            image_a[k*32 +: 32] = $random(seed);
            image_b[k*32 +: 32] = $random(seed);
        end
        image_c = ~image_a;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        // controller boot from flash with a long stall that fills the buffer
        repeat (100) @(posedge core_clk);
        check_val("ctrl_drive", 3'b000, {serial_clock_oe_n, spi_select_oe_n, spi_select_out});
        load_hold <= 1'b1;
        repeat (800) @(posedge core_clk);
        wait_done();
        check_val("header", 40'h0b00000000, header);
        check_val("select_after", 1, spi_select_out);
        read_ram(image_a);
        // abort in mid-load, stay idle while held, then boot again
        reboot(1'b0);
        repeat (300) @(posedge core_clk);
        config_reset_n <= 1'b0;
        repeat (200) @(posedge core_clk);
        check_val("abort_idle", 3'b011, {config_done, serial_clock_oe_n, spi_select_oe_n});
        config_reset_n <= 1'b1;
        wait_done();
        check_val("header_again", 40'h0b00000000, header);
        read_ram(image_a);
        // target mode: program the store, then load the ram
        target_strap <= 1'b1;
        reboot(1'b0);
        repeat (20) @(posedge core_clk);
        check_val("tgt_inputs", 2'b11, {serial_clock_oe_n, spi_select_oe_n});
        host_frame(8'h02, image_b);
        check_val("store_locked", 1, store_locked);
        host_frame(8'h02, image_a);
        host_frame(8'h5a, image_a);
        host_frame(8'h01, image_c);
        wait_done();
        check_val("overrun", 0, target_overrun);
        read_ram(image_c);
        // boot from the onetime store with select sampled high
        target_strap <= 1'b0;
        reboot(1'b1);
        wait_done();
        read_ram(image_b);
        end_of_test();
    end
endmodule

/* File: spi_flash_model.sv */
// behavioural serial flash answering a fast-read header, mode 0 timing
// assumes the loader drives its clock and select; image byte 0 sits at the top bits
`timescale 1ns/1ns
module spi_flash_model #(
    parameter int WORDS = 16
) (
    input  wire logic               sck,
    input  wire logic               cs_n,
    input  wire logic               mosi,
    input  wire logic [WORDS*8-1:0] image,
    output logic                    miso,
    output logic      [39:0]        header
);
    int cnt = 0;
    initial miso = 1'b0;
    initial header = '0;
    // new transfer starts at select fall
    always @(negedge cs_n) cnt = 0;
    // collect command, address and dummy bits on rising clock
    always @(posedge sck) if (!cs_n) begin
        if (cnt < 40) header = {header[38:0], mosi};
        cnt = cnt + 1;
    end
    // data after the header, else a line that keeps changing
    always @(negedge sck or posedge cs_n) begin
        if (!cs_n && cnt >= 40 && cnt - 40 < WORDS * 8) miso <= image[WORDS*8-1-(cnt-40)];
        else miso <= ~miso;
    end
endmodule
